// >>> design/angle_readout_pkg.sv
// constants for the angle sensor readout register bank
package angle_readout_pkg;
	// register byte offsets, each word spans offset and offset+1
	localparam logic [7:0] temp_off = 8'h28;
	localparam logic [7:0] field_off = 8'h2a;
	localparam logic [7:0] turns_off = 8'h2c;
	localparam logic [7:0] hys_off = 8'h30;
	localparam logic [7:0] fine_off = 8'h32;
	localparam logic [7:0] zcd_off = 8'h34;
	// hard-coded register identifiers
	localparam logic [3:0] temp_id = 4'hf;
	localparam logic [3:0] field_id = 4'he;
	localparam logic [2:0] turns_id = 3'h6;
	localparam logic angle_top = 1'b0;
	// field positions
	localparam int id4_lsb = 12;
	localparam int id3_lsb = 13;
	localparam int ef_pos = 14;
	localparam int uv_pos = 13;
	localparam int par_pos = 12;
	localparam int payload_w = 12;
	localparam int fine_w = 15;
	localparam int sector_w = 3;
	// reset values
	localparam logic [15:0] temp_rst = 16'hf000;
	localparam logic [15:0] field_rst = 16'he000;
	localparam logic [15:0] turns_rst = 16'hd000;
	localparam logic [15:0] angle_rst = 16'h1000;
	localparam logic [15:0] fine_rst = 16'h0000;
	// turns counter limits, kept internally in 45 degree steps
	localparam logic signed [11:0] turns_max = 12'sh7ff;
	localparam logic signed [11:0] turns_min = 12'sh800;
	localparam int half_shift = 2;
	// field refresh timing
	localparam int clk_mhz = 250;
	localparam int field_refresh_us = 128;
	localparam int field_refresh_cyc = field_refresh_us * clk_mhz;
endpackage

// >>> design/angle_sensor_readout_regs.sv
// read-only measurement register bank of the angle sensor
`timescale 1ns/1ps
module angle_sensor_readout_regs #(
	parameter int field_refresh_cycles = angle_readout_pkg::field_refresh_cyc
) (
	input wire logic core_clk, // 250 MHz system clock
	input wire logic rstn, // asynchronous reset
	input wire logic rd_req, // read request
	input wire logic [7:0] rd_addr, // byte address of word
	output logic [15:0] rd_data_q, // read word
	output logic rd_ack_q, // read answer strobe
	output logic rd_miss_q, // unmapped address read
	input wire logic temp_valid, // new temperature sample
	input wire logic [11:0] temp_value, // signed eighths of a degree
	input wire logic [11:0] field_value, // live field magnitude
	input wire logic hys_valid, // new tracking-loop angle
	input wire logic [11:0] hys_angle, // hysteresis angle
	input wire logic fine_valid, // new compensated angle
	input wire logic [14:0] fine_angle, // 15-bit compensated angle
	input wire logic zcd_valid, // new zero-crossing sample
	input wire logic [11:0] zcd_angle, // zero-crossing path angle
	input wire logic turns_res_45, // stored turns step, 1 = 45 degrees
	input wire logic [15:0] err_bits, // error register bits
	input wire logic [15:0] err_mask, // error mask bits
	input wire logic [15:0] warn_bits, // warning register bits
	input wire logic [15:0] warn_mask, // warning mask bits
	input wire logic analog_undervoltage_flag, // analog regulator low
	input wire logic digital_undervoltage_flag, // digital regulator low
	input wire logic analog_uv_mask, // suppress analog undervoltage
	input wire logic digital_uv_mask, // suppress digital undervoltage
	output logic turns_overflow_q, // turns count stepped past its limit
	output logic turns_warn_q // sample step too large to count
);

	// odd parity bit over the other fifteen bits of a word
	function automatic logic odd_par(input logic [14:0] bits);
		odd_par = ~(^bits);
	endfunction

	// word match; bit 0 of the byte address only picks a byte, so it is ignored
	function automatic logic word_hit(input logic [7:0] addr, input logic [7:0] off);
		word_hit = (addr[7:1] == off[7:1]);
	endfunction

	logic [15:0] temp_q, temp_d;
	logic [15:0] field_q, field_d;
	logic [15:0] turns_q, turns_d;
	logic [15:0] hys_q, hys_d;
	logic [15:0] fine_q, fine_d;
	logic [15:0] zero_cross_angle_reading_q, zero_cross_angle_reading_d;
	logic [11:0] hys_ang_q;
	logic [11:0] zcd_ang_q;
	logic [31:0] field_cnt_q;
	logic [31:0] field_cnt_d;
	logic field_tick;
	logic signed [11:0] eighths_q, eighths_d;
	logic [2:0] sector_q;
	logic ref_seen_q;
	logic ovf_d, warn_d;
	logic error_summary_flag;
	logic undervoltage_flag;

	// summary error and live undervoltage flags
	assign error_summary_flag = |((err_bits & ~err_mask) | (warn_bits & ~warn_mask));
	assign undervoltage_flag = (analog_undervoltage_flag & ~analog_uv_mask)
		| (digital_undervoltage_flag & ~digital_uv_mask);

	// field refresh timer, free running from reset
	assign field_tick = (field_cnt_q == 32'(field_refresh_cycles - 1));
	assign field_cnt_d = field_tick ? 32'h0000_0000 : field_cnt_q + 32'h0000_0001;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			field_cnt_q <= 32'h0000_0000;
		end else begin
			field_cnt_q <= field_cnt_d;
		end
	end

	// zero-crossing sector tracking in 45 degree steps
	logic [2:0] new_sector;
	logic [2:0] sector_step;
	logic step_big;
	logic step_up;
	logic step_dn;
	logic at_max;
	logic at_min;

	assign new_sector = zcd_angle[11:9];
	assign sector_step = new_sector - sector_q;
	// a half-turn jump has no known direction, so it is flagged and not counted
	assign step_big = ref_seen_q & zcd_valid & (sector_step == 3'h4);
	assign step_up = ref_seen_q & zcd_valid & (sector_step != 3'h0) & ~sector_step[2];
	assign step_dn = ref_seen_q & zcd_valid & sector_step[2] & (sector_step != 3'h4);
	assign at_max = (eighths_q == angle_readout_pkg::turns_max);
	assign at_min = (eighths_q == angle_readout_pkg::turns_min);

	// counter saturates; a step past a limit raises overflow
	logic [11:0] step_mag;
	assign step_mag = {10'h000, (step_up ? sector_step[1:0] : 2'(-sector_step))};

	logic signed [12:0] sum_up;
	logic signed [12:0] sum_dn;
	assign sum_up = 13'(eighths_q) + 13'(step_mag);
	assign sum_dn = 13'(eighths_q) - 13'(step_mag);

	always_comb begin
		eighths_d = eighths_q;
		ovf_d = turns_overflow_q;
		warn_d = turns_warn_q | step_big;
		if (step_up) begin
			if (sum_up > 13'(angle_readout_pkg::turns_max) || at_max) begin
				eighths_d = angle_readout_pkg::turns_max;
				ovf_d = 1'b1;
			end else begin
				eighths_d = sum_up[11:0];
			end
		end else if (step_dn) begin
			if (sum_dn < 13'(angle_readout_pkg::turns_min) || at_min) begin
				eighths_d = angle_readout_pkg::turns_min;
				ovf_d = 1'b1;
			end else begin
				eighths_d = sum_dn[11:0];
			end
		end
	end

	// turns value in the selected step size
	logic signed [11:0] turns_half;
	logic [11:0] turns_value;
	assign turns_half = eighths_q >>> angle_readout_pkg::half_shift;
	assign turns_value = turns_res_45 ? eighths_q : turns_half;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			eighths_q <= 12'sh000;
			sector_q <= 3'h0;
			ref_seen_q <= 1'b0;
			turns_overflow_q <= 1'b0;
			turns_warn_q <= 1'b0;
		end else begin
			// first sample after reset is the zero reference
			if (zcd_valid) begin
				sector_q <= new_sector;
				ref_seen_q <= 1'b1;
			end
			eighths_q <= eighths_d;
			turns_overflow_q <= ovf_d;
			turns_warn_q <= warn_d;
		end
	end

	// hysteresis angle holding register, loaded on each tracking-loop sample
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			hys_ang_q <= 12'h000;
		end else begin
			if (hys_valid) begin
				hys_ang_q <= hys_angle;
			end
		end
	end

	// zero-crossing angle holding register, same sample that drives turns counting
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			zcd_ang_q <= 12'h000;
		end else begin
			if (zcd_valid) begin
				zcd_ang_q <= zcd_angle;
			end
		end
	end

	// parity bodies: the fifteen non-parity bits of each word, identifier, flags and payload
	logic [14:0] turns_body;
	logic [14:0] hys_body;
	logic [14:0] zero_cross_angle_reading_body;
	assign turns_body = {angle_readout_pkg::turns_id, turns_value};
	assign hys_body = {error_summary_flag, undervoltage_flag, 1'b0, hys_ang_q};
	assign zero_cross_angle_reading_body = {error_summary_flag, undervoltage_flag, 1'b0, zcd_ang_q};

	// parity bits; the identifier counts too, so it must sit whole in the body
	logic turns_par;
	logic hys_par;
	logic zero_cross_angle_reading_par;
	assign turns_par = odd_par(turns_body);
	assign hys_par = odd_par(hys_body);
	assign zero_cross_angle_reading_par = odd_par(zero_cross_angle_reading_body);

	assign temp_d = temp_valid ? {angle_readout_pkg::temp_id, temp_value} : temp_q;
	assign field_d = field_tick ? {angle_readout_pkg::field_id, field_value} : field_q;
	assign turns_d = {angle_readout_pkg::turns_id, turns_par, turns_value};
	assign hys_d = {angle_readout_pkg::angle_top, error_summary_flag, undervoltage_flag,
		hys_par, hys_ang_q};
	assign fine_d = fine_valid ? {1'b0, fine_angle} : fine_q;
	assign zero_cross_angle_reading_d = {angle_readout_pkg::angle_top, error_summary_flag, undervoltage_flag,
		zero_cross_angle_reading_par, zcd_ang_q};

	// temperature image, loaded as one word so a read never splits an update
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			temp_q <= angle_readout_pkg::temp_rst;
		end else begin
			temp_q <= temp_d;
		end
	end

	// field image, changes only on a refresh tick
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			field_q <= angle_readout_pkg::field_rst;
		end else begin
			field_q <= field_d;
		end
	end

	// turns image, rebuilt every cycle so the step size setting takes effect at once
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			turns_q <= angle_readout_pkg::turns_rst;
		end else begin
			turns_q <= turns_d;
		end
	end

	// hysteresis angle image; live flags cost one cycle of latency here
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			hys_q <= angle_readout_pkg::angle_rst;
		end else begin
			hys_q <= hys_d;
		end
	end

	// compensated angle image
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			fine_q <= angle_readout_pkg::fine_rst;
		end else begin
			fine_q <= fine_d;
		end
	end

	// zero-crossing angle image, same flag latency as the hysteresis word
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			zero_cross_angle_reading_q <= angle_readout_pkg::angle_rst;
		end else begin
			zero_cross_angle_reading_q <= zero_cross_angle_reading_d;
		end
	end

	// read decode, either byte address of a word returns the word
	logic hit_temp;
	logic hit_field;
	logic hit_turns;
	logic hit_hys;
	logic hit_fine;
	logic hit_zero_cross_angle_reading;
	logic rd_hit;
	logic [15:0] rd_word;

	assign hit_temp = word_hit(rd_addr, angle_readout_pkg::temp_off);
	assign hit_field = word_hit(rd_addr, angle_readout_pkg::field_off);
	assign hit_turns = word_hit(rd_addr, angle_readout_pkg::turns_off);
	assign hit_hys = word_hit(rd_addr, angle_readout_pkg::hys_off);
	assign hit_fine = word_hit(rd_addr, angle_readout_pkg::fine_off);
	assign hit_zero_cross_angle_reading = word_hit(rd_addr, angle_readout_pkg::zcd_off);
	assign rd_hit = hit_temp | hit_field | hit_turns | hit_hys | hit_fine | hit_zero_cross_angle_reading;
	assign rd_word = ({16{hit_temp}} & temp_q)
		| ({16{hit_field}} & field_q)
		| ({16{hit_turns}} & turns_q)
		| ({16{hit_hys}} & hys_q)
		| ({16{hit_fine}} & fine_q)
		| ({16{hit_zero_cross_angle_reading}} & zero_cross_angle_reading_q);

	// read answer one cycle after the request; unmapped words read zero
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rd_data_q <= 16'h0000;
			rd_ack_q <= 1'b0;
			rd_miss_q <= 1'b0;
		end else begin
			rd_ack_q <= rd_req;
			rd_miss_q <= rd_req & ~rd_hit;
			if (rd_req) begin
				rd_data_q <= rd_word;
			end
		end
	end

endmodule

// >>> verification/readout_assertions.sv
// port assertions for the readout register bank
`timescale 1ns/1ps
module readout_checker (
	input wire logic core_clk, // clock
	input wire logic rstn, // reset
	input wire logic rd_req, // read
	input wire logic [7:0] rd_addr, // address
	input wire logic [15:0] rd_data_q, // word
	input wire logic rd_ack_q, // answer
	input wire logic rd_miss_q, // miss
	input wire logic [15:0] err_bits, // errors
	input wire logic [15:0] err_mask, // error mask
	input wire logic [15:0] warn_bits, // warnings
	input wire logic [15:0] warn_mask, // warning mask
	input wire logic turns_overflow_q // saturated
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// word selects; bit 0 of the address is ignored
	wire [6:0] wa = rd_addr[7:1];
	wire rt = rd_req && wa == 7'h14;
	wire rf = rd_req && wa == 7'h15;
	wire rn = rd_req && wa == 7'h16;
	wire rh = rd_req && wa == 7'h18;
	wire rg = rd_req && wa == 7'h19;
	wire rz = rd_req && wa == 7'h1a;
	wire mapped = rt || rf || rn || rh || rg || rz;
	wire ef = |((err_bits & ~err_mask) | (warn_bits & ~warn_mask));
	sequence s_ans;
		rd_ack_q && !rd_miss_q;
	endsequence
	sequence s_miss;
		rd_ack_q && rd_miss_q && rd_data_q == 16'h0;
	endsequence
	chk_ack_timing: assert property (rd_ack_q == $past(rd_req))
		else $error("answer strobe not one cycle after read");
	chk_mapped_answer: assert property (mapped |=> s_ans)
		else $error("mapped read answered as miss");
	chk_miss_zero: assert property (rd_req && !mapped |=> s_miss)
		else $error("unmapped read not flagged with zero data");
	chk_temp_id: assert property (rt |=> rd_data_q[15:12] == 4'hf)
		else $error("temperature word id wrong");
	chk_field_id: assert property (rf |=> rd_data_q[15:12] == 4'he)
		else $error("field word id wrong");
	chk_turns_parity: assert property (rn |=> rd_data_q[15:13] == 3'h6 && ^rd_data_q)
		else $error("turns word id or parity wrong");
	chk_angle_parity: assert property (rh || rz |=> !rd_data_q[15] && ^rd_data_q)
		else $error("angle word top bit or parity wrong");
	chk_fine_top: assert property (rg |=> !rd_data_q[15])
		else $error("fine angle top bit set");
	chk_error_flag: assert property (rh |=> rd_data_q[14] == $past(ef, 2))
		else $error("error summary flag wrong");
	chk_ovf_sticky: assert property (turns_overflow_q |=> turns_overflow_q)
		else $error("overflow flag dropped");
endmodule
bind angle_sensor_readout_regs readout_checker chk (.core_clk(core_clk), .rstn(rstn), .rd_req(rd_req),
	.rd_addr(rd_addr), .rd_data_q(rd_data_q), .rd_ack_q(rd_ack_q), .rd_miss_q(rd_miss_q), .err_bits(err_bits),
	.err_mask(err_mask), .warn_bits(warn_bits), .warn_mask(warn_mask), .turns_overflow_q(turns_overflow_q));

// >>> verification/host_reader.sv
// register host model issuing single reads
`timescale 1ns/1ps
module host_reader (
	input wire logic core_clk, // clock
	input wire logic rd_ack_q, // answer
	input wire logic rd_miss_q, // miss
	input wire logic [15:0] rd_data_q, // word
	output logic rd_req, // read
	output logic [7:0] rd_addr // address
);
	initial begin
		rd_req = 1'b0;
		rd_addr = 8'hff;
	end
	// one-cycle request; idle address is scrambled so a stale value never looks valid
	task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic ok, output logic m);
		@(posedge core_clk) #1;
		rd_req = 1'b1;
		rd_addr = a;
		@(posedge core_clk) #1;
		ok = rd_ack_q;
		d = rd_data_q;
		m = rd_miss_q;
		rd_req = 1'b0;
		rd_addr = ~a;
	endtask
endmodule

// >>> verification/angle_sensor_readout_regs_tb_top.sv
// self-checking bench for the readout register bank
`timescale 1ns/1ps
module angle_sensor_readout_regs_tb_top;
	logic core_clk, rstn, rd_req, rd_ack_q, rd_miss_q, tv, hv, fv, zv, res45, au, du, am, dm, ovf, warn;
	logic [7:0] rd_addr;
	logic [15:0] rd_data_q, eb, em, wb, wm;
	logic [11:0] tval, fld, ha, za;
	logic [14:0] fa;
	int errors = 0, check_count = 0, cyc = 0;
	angle_sensor_readout_regs #(.field_refresh_cycles(8)) DUT (.core_clk(core_clk), .rstn(rstn),
		.rd_req(rd_req), .rd_addr(rd_addr), .rd_data_q(rd_data_q), .rd_ack_q(rd_ack_q), .rd_miss_q(rd_miss_q),
		.temp_valid(tv), .temp_value(tval), .field_value(fld), .hys_valid(hv), .hys_angle(ha), .fine_valid(fv),
		.fine_angle(fa), .zcd_valid(zv), .zcd_angle(za), .turns_res_45(res45), .err_bits(eb), .err_mask(em),
		.warn_bits(wb), .warn_mask(wm), .analog_undervoltage_flag(au), .digital_undervoltage_flag(du),
		.analog_uv_mask(am), .digital_uv_mask(dm), .turns_overflow_q(ovf), .turns_warn_q(warn));
	host_reader host (.core_clk(core_clk), .rd_ack_q(rd_ack_q), .rd_miss_q(rd_miss_q), .rd_data_q(rd_data_q),
		.rd_req(rd_req), .rd_addr(rd_addr));
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	// a hung test costs a mismatch instead of a silent stall
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			stop_test();
		end
	end
	task automatic tk(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic cmp16(input string n, input logic [15:0] e, s);
		check_count++;
		if (s !== e) begin
			errors++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic cmp1(input string n, input logic e, s);
		check_count++;
		if (s !== e) begin
			errors++;
			$display("BAD %s expected %b seen %b", n, e, s);
		end
	endtask
	// parity bit 12 is chosen so the word holds an odd count of ones
	function automatic logic [15:0] aw(input logic e, u, input logic [11:0] a);
		aw = {1'b0, e, u, 1'b0, a};
		aw[12] = ~^aw;
	endfunction
	function automatic logic [15:0] tw(input logic [11:0] c);
		tw = {3'h6, 1'b0, c};
		tw[12] = ~^tw;
	endfunction
	task automatic rw(input logic [7:0] a, input logic [15:0] e, input string n);
		logic [15:0] d;
		logic ok, m;
		host.rd(a, d, ok, m);
		cmp1({n, " ack"}, 1'b1, ok);
		cmp1({n, " miss"}, 1'b0, m);
		cmp16(n, e, d);
	endtask
	task automatic zs(input logic [11:0] a);
		za = a;
		zv = 1'b1;
		tk(1);
		zv = 1'b0;
		tk(1);
	endtask
	task automatic t_reset;
		logic [15:0] d;
		logic ok, m;
		rw(8'h28, 16'hf000, "temp");
		rw(8'h2b, 16'he000, "field");
		rw(8'h2c, 16'hd000, "turns");
		rw(8'h30, 16'h1000, "hys");
		rw(8'h32, 16'h0000, "fine");
		rw(8'h34, 16'h1000, "zero_cross_angle_reading");
		host.rd(8'h2e, d, ok, m);
		cmp1("miss", 1'b1, m);
		cmp16("miss data", 16'h0, d);
		$display("test reset done");
	endtask
	task automatic t_meas;
		tval = 12'h800;
		ha = 12'habc;
		fa = 15'h5a5a;
		fld = 12'h3a5;
		{tv, hv, fv} = 3'h7;
		zs(12'h0a5);
		{tv, hv, fv} = 3'h0;
		tk(10);
		rw(8'h29, 16'hf800, "temp");
		rw(8'h2a, 16'he3a5, "field");
		rw(8'h31, aw(1'b0, 1'b0, 12'habc), "hys");
		rw(8'h33, 16'h5a5a, "fine");
		rw(8'h35, aw(1'b0, 1'b0, 12'h0a5), "zero_cross_angle_reading");
		rw(8'h2c, tw(12'h0), "turns ref");
		$display("test measure done");
	endtask
	task automatic fl(input logic [15:0] b, k, w, x, input logic [3:0] v, input logic [1:0] f);
		{eb, em, wb, wm} = {b, k, w, x};
		{au, du, am, dm} = v;
		tk(2);
		rw(8'h30, aw(f[1], f[0], 12'habc), "hys flags");
		rw(8'h34, aw(f[1], f[0], 12'h0a5), "zero_cross_angle_reading flags");
	endtask
	task automatic t_flags;
		fl(16'h1, 16'h0, 16'h0, 16'h0, 4'h0, 2'h2);
		fl(16'h1, 16'h1, 16'h0, 16'h0, 4'h0, 2'h0);
		fl(16'h0, 16'h0, 16'h8000, 16'h0, 4'h8, 2'h3);
		fl(16'h0, 16'h0, 16'h8000, 16'h8000, 4'ha, 2'h0);
		fl(16'h0, 16'h0, 16'h0, 16'h0, 4'h5, 2'h0);
		fl(16'h0, 16'h0, 16'h0, 16'h0, 4'h4, 2'h1);
		$display("test flags done");
	endtask
	task automatic t_turns;
		logic [2:0] s;
		zs(12'h200);
		zs(12'h400);
		zs(12'h300);
		rw(8'h2c, tw(12'h1), "turns 45");
		res45 = 1'b0;
		rw(8'h2c, tw(12'h0), "turns 180");
		zs(12'h000);
		zs(12'he00);
		rw(8'h2c, tw(12'hfff), "turns 180 neg");
		res45 = 1'b1;
		rw(8'h2c, tw(12'hfff), "turns 45 neg");
		s = 3'h7;
		repeat (2048) begin
			s = s + 3'h1;
			zs({s, 9'h0a5});
		end
		cmp1("overflow early", 1'b0, ovf);
		zs({s + 3'h1, 9'h0a5});
		cmp1("overflow", 1'b1, ovf);
		rw(8'h2c, tw(12'h7ff), "turns max 45");
		res45 = 1'b0;
		rw(8'h2c, tw(12'h1ff), "turns max 180");
		// a half-turn jump has no known direction: it is flagged and not counted
		cmp1("warn early", 1'b0, warn);
		zs({s + 3'h5, 9'h0a5});
		cmp1("warn", 1'b1, warn);
		rw(8'h2c, tw(12'h1ff), "turns after jump");
		$display("test turns done");
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		{rstn, tv, hv, fv, zv, au, du, am, dm} = 9'h0;
		{eb, em, wb, wm} = 64'h0;
		{tval, fld, ha, za, fa} = 63'h0;
		res45 = 1'b1;
		tk(6);
		rstn = 1'b1;
		t_reset();
		t_meas();
		t_flags();
		t_turns();
		stop_test();
	end
endmodule
